// file: refctl_pkg.sv
// package: offsets, field positions, reset values and variant codes
// assumes a single 20 MHz core clock and a plain strobe register port
package refctl_pkg;
    localparam logic [7:0] REF_CTRL_ADDR      = 8'hD1;
    localparam logic [7:0] REF_CTRL_PAGE      = 8'h00;
    localparam logic [7:0] REF_CTRL_RESET     = 8'h00;
    localparam logic [7:0] REF_CTRL_IMPL_MASK = 8'h1F;
    localparam logic [7:0] REF_CTRL_SEL_MASK  = 8'h18;
    localparam int         BIT_PRIMARY_SEL    = 4;
    localparam int         BIT_SECONDARY_SEL  = 3;
    localparam int         BIT_TEMP_EN        = 2;
    localparam int         BIT_BIAS_EN        = 1;
    localparam int         BIT_BUF_EN         = 0;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;
    // variant codes
    localparam logic [1:0] VARIANT_SPLIT_PIN  = 2'h0;
    localparam logic [1:0] VARIANT_SHARED_PIN = 2'h1;
    localparam logic [1:0] VARIANT_NO_DAC     = 2'h2;
    // reference source codes on the select outputs
    localparam logic [1:0] SRC_PRIMARY_PIN    = 2'h0;
    localparam logic [1:0] SRC_SECONDARY_PIN  = 2'h1;
    localparam logic [1:0] SRC_SHARED_PIN     = 2'h2;
    localparam logic [1:0] SRC_INTERNAL       = 2'h3;
endpackage : refctl_pkg

// file: ref_src_mux.sv
// reference source decode for one converter
// assumes the select bit comes straight from the control register
`timescale 1ns/1ns
module ref_src_mux #(
    parameter logic [1:0] PIN_SRC = 2'h0
) (
    input  wire logic       sel,
    input  wire logic       has_sel,
    input  wire logic       shared_pin,
    output logic [1:0]      src
);
    always_comb begin
        if (!has_sel || !sel) begin
            src = shared_pin ? refctl_pkg::SRC_SHARED_PIN : PIN_SRC;
        end else begin
            src = refctl_pkg::SRC_INTERNAL;
        end
    end
endmodule : ref_src_mux

// file: temp_sense_mux.sv
// temperature sensor hookup to the last primary converter input
// assumes the converter mux treats a low valid as high impedance
`timescale 1ns/1ns
module temp_sense_mux #(
    parameter int CH_BITS = 3
) (
    input  wire logic               temp_en,
    output logic [CH_BITS-1:0]      sensor_channel,
    output logic                    sensor_valid
);
    assign sensor_channel = {CH_BITS{1'b1}};
    assign sensor_valid   = temp_en;
endmodule : temp_sense_mux

// file: analog_reference_control_register.sv
// analog reference control register: enables and reference selects
// assumes synchronous register strobes, one clock, synchronous reset
`timescale 1ns/1ns
// Summary of operation
// - bits seven to five read zero and ignore writes
// - reset clears every bit; enables off, selects on pins
// - bit four picks primary reference: pin or first dac output
// - bit three picks secondary reference: pin or analog supply rail
// - shared-pin variant routes cleared selects from the common pin
// - bit two drives the temperature sensor enable
// - bit one drives the bias generator enable
// - bit zero drives the reference buffer enable
// - register decodes at d1 on page zero
// - enabled sensor feeds top primary input, else high impedance
module analog_reference_control_register #(
    parameter logic [1:0] VARIANT = refctl_pkg::VARIANT_SPLIT_PIN,
    parameter int         CH_BITS = 3
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_page,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    output logic                    temp_sensor_enable,
    output logic                    bias_generator_enable,
    output logic                    reference_buffer_enable,
    output logic [1:0]              primary_ref_source,
    output logic [1:0]              secondary_ref_source,
    output logic [CH_BITS-1:0]      sensor_channel,
    output logic                    sensor_valid
);
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] next_rdata;
    logic       hit;
    logic       has_sel;
    logic       shared_pin;

    assign has_sel    = (VARIANT != refctl_pkg::VARIANT_NO_DAC);
    assign shared_pin = (VARIANT == refctl_pkg::VARIANT_SHARED_PIN);

    assign hit = (reg_addr == refctl_pkg::REF_CTRL_ADDR)
              && (reg_page == refctl_pkg::REF_CTRL_PAGE);

    always_comb begin
        next_ctrl  = ctrl;
        next_rdata = refctl_pkg::UNMAPPED_READ;
        if (reg_wr && hit) begin
            next_ctrl = reg_wdata & refctl_pkg::REF_CTRL_IMPL_MASK;
            // selects kept zero where no selection exists
            if (!has_sel) begin
                next_ctrl = next_ctrl & ~refctl_pkg::REF_CTRL_SEL_MASK;
            end
        end
        if (reg_rd && hit) begin
            next_rdata = ctrl;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl      <= refctl_pkg::REF_CTRL_RESET;
            reg_rdata <= 8'h00;
        end else begin
            ctrl      <= next_ctrl;
            reg_rdata <= next_rdata;
        end
    end

    assign temp_sensor_enable      = ctrl[refctl_pkg::BIT_TEMP_EN];
    // bias enable follows bit one; software keeps it set
    assign bias_generator_enable   = ctrl[refctl_pkg::BIT_BIAS_EN];
    assign reference_buffer_enable = ctrl[refctl_pkg::BIT_BUF_EN];

    ref_src_mux #(
        .PIN_SRC (refctl_pkg::SRC_PRIMARY_PIN)
    ) u_primary (
        .sel        (ctrl[refctl_pkg::BIT_PRIMARY_SEL]),
        .has_sel    (has_sel),
        .shared_pin (shared_pin),
        .src        (primary_ref_source)
    );

    ref_src_mux #(
        .PIN_SRC (refctl_pkg::SRC_SECONDARY_PIN)
    ) u_secondary (
        .sel        (ctrl[refctl_pkg::BIT_SECONDARY_SEL]),
        .has_sel    (has_sel),
        .shared_pin (shared_pin),
        .src        (secondary_ref_source)
    );

    temp_sense_mux #(
        .CH_BITS (CH_BITS)
    ) u_temp (
        .temp_en        (temp_sensor_enable),
        .sensor_channel (sensor_channel),
        .sensor_valid   (sensor_valid)
    );

    a_upper_zero: assert property (@(posedge clk) disable iff (rst)
        reg_rd |=> reg_rdata[7:5] == 3'h0) else $error("upper bits not zero");
    a_reset_clear: assert property (@(posedge clk)
        rst |=> ctrl == 8'h00 && !bias_generator_enable) else $error("reset not clear");
    a_primary_int: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && hit && reg_wdata[4] && has_sel) |=>
        primary_ref_source == refctl_pkg::SRC_INTERNAL) else $error("primary sel");
    a_second_int: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && hit && reg_wdata[3] && has_sel) |=>
        secondary_ref_source == refctl_pkg::SRC_INTERNAL) else $error("secondary sel");
    a_shared_route: assert property (@(posedge clk) disable iff (rst)
        (shared_pin && !ctrl[4]) |->
        primary_ref_source == refctl_pkg::SRC_SHARED_PIN) else $error("shared pin");
    a_temp_follow: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && hit) |=> temp_sensor_enable == $past(reg_wdata[2])) else $error("temp");
    a_bias_follow: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && hit) |=> bias_generator_enable == $past(reg_wdata[1])) else $error("bias");
    a_buf_follow: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && hit) |=> reference_buffer_enable == $past(reg_wdata[0])) else $error("buf");
    a_decode_only: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && !hit) |=> $stable(ctrl)) else $error("stray write");
    a_sensor_link: assert property (@(posedge clk) disable iff (rst)
        sensor_valid == temp_sensor_enable) else $error("sensor");
    a_read_back: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && hit ##1 reg_rd && hit) |=>
        reg_rdata == ($past(reg_wdata, 2) & (has_sel ? 8'h1F : 8'h07))) else $error("readback");
endmodule : analog_reference_control_register

// file: analog_reference_control_register_bench.sv
// bench: strobe-port writes and reads, output decode of the shared-pin build
// assumes the package constants and one-cycle read answer of the register port
`timescale 1ns/1ns
module analog_reference_control_register_bench;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_page = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       temp_sensor_enable;
    logic       bias_generator_enable;
    logic       reference_buffer_enable;
    logic [1:0] primary_ref_source;
    logic [1:0] secondary_ref_source;
    logic [2:0] sensor_channel;
    logic       sensor_valid;
    logic [7:0] nd_rdata;
    logic [1:0] nd_primary;
    logic [1:0] nd_secondary;
    logic [7:0] shadow = 8'h00;
    logic [31:0] seed = 32'h00000051;
    int         mismatches = 0;
    int         checks_done = 0;

    analog_reference_control_register #(
        .VARIANT(refctl_pkg::VARIANT_SHARED_PIN), .CH_BITS(3)
    ) dut_u (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_page(reg_page),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .temp_sensor_enable(temp_sensor_enable),
        .bias_generator_enable(bias_generator_enable),
        .reference_buffer_enable(reference_buffer_enable),
        .primary_ref_source(primary_ref_source), .secondary_ref_source(secondary_ref_source),
        .sensor_channel(sensor_channel), .sensor_valid(sensor_valid)
    );

    // no-dac build on the same bus: selects must never leave their pins
    analog_reference_control_register #(
        .VARIANT(refctl_pkg::VARIANT_NO_DAC), .CH_BITS(3)
    ) dut_u_nd (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_page(reg_page),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(nd_rdata),
        .temp_sensor_enable(),
        .bias_generator_enable(),
        .reference_buffer_enable(),
        .primary_ref_source(nd_primary), .secondary_ref_source(nd_secondary),
        .sensor_channel(), .sensor_valid()
    );

    always #25 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    function automatic logic [1:0] src(input logic b);
        return b ? refctl_pkg::SRC_INTERNAL : refctl_pkg::SRC_SHARED_PIN;
    endfunction : src

    function automatic logic hit(input logic [7:0] a, input logic [7:0] p);
        return a == refctl_pkg::REF_CTRL_ADDR && p == refctl_pkg::REF_CTRL_PAGE;
    endfunction : hit

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        reg_addr  <= a;
        reg_page  <= p;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (hit(a, p)) shadow = d & refctl_pkg::REF_CTRL_IMPL_MASK;
    endtask : wr

    // extra idle cycle so the cleared data after the answer is seen too
    task automatic rd(input logic [7:0] a, input logic [7:0] p);
        reg_addr <= a;
        reg_page <= p;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        cmp(reg_rdata, hit(a, p) ? shadow : refctl_pkg::UNMAPPED_READ);
        cmp(nd_rdata, hit(a, p) ? (shadow & ~refctl_pkg::REF_CTRL_SEL_MASK)
                                : refctl_pkg::UNMAPPED_READ);
        cmp({6'h00, nd_primary}, {6'h00, refctl_pkg::SRC_PRIMARY_PIN});
        cmp({6'h00, nd_secondary}, {6'h00, refctl_pkg::SRC_SECONDARY_PIN});
        cmp({7'h00, temp_sensor_enable}, {7'h00, shadow[2]});
        cmp({7'h00, bias_generator_enable}, {7'h00, shadow[1]});
        cmp({7'h00, reference_buffer_enable}, {7'h00, shadow[0]});
        cmp({6'h00, primary_ref_source}, {6'h00, src(shadow[4])});
        cmp({6'h00, secondary_ref_source}, {6'h00, src(shadow[3])});
        cmp({4'h0, sensor_valid, sensor_channel}, {4'h0, shadow[2], 3'h7});
        @(negedge clk);
        cmp(reg_rdata, 8'h00);
        cmp(nd_rdata, 8'h00);
        @(posedge clk);
    endtask : rd

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(8'hD1, 8'h00);
        $display("test reset done");
        wr(8'hD1, 8'h00, 8'hFF);
        rd(8'hD1, 8'h00);
        // bias on before the converters are used, reserved selects written zero
        wr(8'hD1, 8'h00, 8'h07);
        rd(8'hD1, 8'h00);
        wr(8'hD0, 8'h00, 8'h00);
        wr(8'hD1, 8'h01, 8'h00);
        rd(8'hD1, 8'h01);
        rd(8'hD1, 8'h00);
        $display("test decode done");
        for (int i = 0; i < 60; i++) begin
            seed = xs(seed);
            wr(seed[9:8] != 2'h0 ? 8'hD1 : seed[7:0], {7'h00, seed[11:10] == 2'h0}, seed[31:24]);
            rd(8'hD1, 8'h00);
        end
        $display("test random done");
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        shadow = 8'h00;
        rd(8'hD1, 8'h00);
        $display("test second reset done");
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule : analog_reference_control_register_bench
